// *** core/tcm_pkg.sv ***
/*
  Package of the timer compare match unit: register offsets, field positions,
  reset values, compare mode codes, action states and the carrier structs.
  Assumes a byte-addressed APB bus with 32-bit data, one register per word.
*/
package tcm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COMPARE_CONTROL    = 8'h00;
  localparam logic [7:0] OFF_COMPARE_VALUE_LOW  = 8'h04;
  localparam logic [7:0] OFF_COMPARE_VALUE_HIGH = 8'h08;
  localparam logic [7:0] OFF_ALT_PIN_SELECT     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE         = 8'h10;
  localparam logic [7:0] OFF_IRQ_FLAGS          = 8'h14;
  localparam logic [7:0] OFF_TIMER_COUNT_LOW    = 8'h18;
  localparam logic [7:0] OFF_TIMER_COUNT_HIGH   = 8'h1C;

  // Reset values
  localparam logic [7:0] RST_COMPARE_CONTROL = 8'h00;
  localparam logic [7:0] RST_COMPARE_VALUE   = 8'h00;
  localparam logic [7:0] RST_ALT_PIN_SELECT  = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE      = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS       = 8'h00;

  // Field positions
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_MSB      = 3;
  localparam int unsigned CMP_FLAG_BIT  = 2;
  localparam int unsigned OVF_FLAG_BIT  = 0;
  localparam int unsigned ROUTE_BIT     = 0;

  // Compare mode field codes
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET    = 4'h8;
  localparam logic [3:0] MODE_CLEAR  = 4'h9;
  localparam logic [3:0] MODE_SWINT  = 4'hA;
  localparam logic [3:0] MODE_SEV    = 4'hB;

  // Action selected by the mode field
  typedef enum logic [5:0] {
    ACT_NONE   = 6'b000001,
    ACT_SET    = 6'b000010,
    ACT_CLEAR  = 6'b000100,
    ACT_TOGGLE = 6'b001000,
    ACT_SWINT  = 6'b010000,
    ACT_SEV    = 6'b100000
  } tcm_action_t;

  // Signals from the sixteen_bit_timer
  typedef struct packed {
    logic [15:0] count;
    logic        tick;
    logic        overflow;
  } tcm_timer_t;

  // Signals to the timer and the ADC start logic
  typedef struct packed {
    logic trigger;
    logic timer_reset;
    logic adc_start;
  } tcm_event_t;

endpackage

// *** core/tcm_top.sv ***
/*
  Timer compare match unit: compares a 16-bit value against the timer count,
  drives the match output pin, fires the special event trigger, raises IRQs.
  Assumes the timer, port direction latch and ADC run on pclk as plain logic.
*/
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps

module tcm_top (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Timer and ADC
  input  wire tcm_pkg::tcm_timer_t timer_in,
  input  wire logic               adc_enabled,
  output tcm_pkg::tcm_event_t     event_out,
  // Pin side
  input  wire logic               pin_direction_bit,
  output logic                    pin_main_out,
  output logic                    pin_main_oe,
  output logic                    pin_alt_out,
  output logic                    pin_alt_oe,
  // Interrupt
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]          compare_control_reg;
  logic [7:0]          compare_value_low_reg;
  logic [7:0]          compare_value_high_reg;
  logic [7:0]          alternate_pin_select_reg;
  logic [7:0]          peripheral_irq_enable_reg;
  logic [7:0]          peripheral_irq_flags_reg;
  logic [7:0]          peripheral_irq_flags_next;
  logic [31:0]         prdata_reg;
  logic                pslverr_reg;
  logic                out_latch_reg;
  logic                out_latch_next;
  logic                match_prev_reg;
  logic                wr_en;
  logic                rd_setup;
  logic                addr_hit;
  logic                match;
  logic                match_rise;
  logic                pin_owned;
  logic                drive_oe;
  logic [3:0]          compare_mode_field;
  logic [15:0]         compare_value;
  logic [7:0]          rd_mux;
  tcm_pkg::tcm_action_t action;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 8'h00;
    if (paddr == tcm_pkg::OFF_COMPARE_CONTROL) begin
      rd_mux = compare_control_reg;
    end else if (paddr == tcm_pkg::OFF_COMPARE_VALUE_LOW) begin
      rd_mux = compare_value_low_reg;
    end else if (paddr == tcm_pkg::OFF_COMPARE_VALUE_HIGH) begin
      rd_mux = compare_value_high_reg;
    end else if (paddr == tcm_pkg::OFF_ALT_PIN_SELECT) begin
      rd_mux = alternate_pin_select_reg;
    end else if (paddr == tcm_pkg::OFF_IRQ_ENABLE) begin
      rd_mux = peripheral_irq_enable_reg;
    end else if (paddr == tcm_pkg::OFF_IRQ_FLAGS) begin
      rd_mux = peripheral_irq_flags_reg;
    end else if (paddr == tcm_pkg::OFF_TIMER_COUNT_LOW) begin
      rd_mux = timer_in.count[7:0];
    end else if (paddr == tcm_pkg::OFF_TIMER_COUNT_HIGH) begin
      rd_mux = timer_in.count[15:8];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (rd_setup) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      pslverr_reg <= !addr_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_control_reg <= tcm_pkg::RST_COMPARE_CONTROL;
    end else if (wr_en && paddr == tcm_pkg::OFF_COMPARE_CONTROL) begin
      compare_control_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_low_reg  <= tcm_pkg::RST_COMPARE_VALUE;
      compare_value_high_reg <= tcm_pkg::RST_COMPARE_VALUE;
    end else if (wr_en && paddr == tcm_pkg::OFF_COMPARE_VALUE_LOW) begin
      compare_value_low_reg <= pwdata[7:0];
    end else if (wr_en && paddr == tcm_pkg::OFF_COMPARE_VALUE_HIGH) begin
      compare_value_high_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alternate_pin_select_reg <= tcm_pkg::RST_ALT_PIN_SELECT;
    end else if (wr_en && paddr == tcm_pkg::OFF_ALT_PIN_SELECT) begin
      alternate_pin_select_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enable_reg <= tcm_pkg::RST_IRQ_ENABLE;
    end else if (wr_en && paddr == tcm_pkg::OFF_IRQ_ENABLE) begin
      peripheral_irq_enable_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match detection and action decode
  assign compare_mode_field = compare_control_reg[tcm_pkg::MODE_MSB:tcm_pkg::MODE_LSB];
  assign compare_value      = {compare_value_high_reg, compare_value_low_reg};
  assign match              = (compare_value == timer_in.count);
  assign match_rise         = match && !match_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_reg <= 1'b0;
    end else begin
      match_prev_reg <= match;
    end
  end

  always_comb begin
    case (compare_mode_field)
      tcm_pkg::MODE_TOGGLE: action = tcm_pkg::ACT_TOGGLE;
      tcm_pkg::MODE_SET:    action = tcm_pkg::ACT_SET;
      tcm_pkg::MODE_CLEAR:  action = tcm_pkg::ACT_CLEAR;
      tcm_pkg::MODE_SWINT:  action = tcm_pkg::ACT_SWINT;
      tcm_pkg::MODE_SEV:    action = tcm_pkg::ACT_SEV;
      default:              action = tcm_pkg::ACT_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch
  always_comb begin
    out_latch_next = out_latch_reg;
    if (wr_en && paddr == tcm_pkg::OFF_COMPARE_CONTROL && pwdata[7:0] == 8'h00) begin
      out_latch_next = 1'b0;
    end else if (match_rise) begin
      case (action)
        tcm_pkg::ACT_SET:    out_latch_next = 1'b1;
        tcm_pkg::ACT_CLEAR:  out_latch_next = 1'b0;
        tcm_pkg::ACT_TOGGLE: out_latch_next = !out_latch_reg;
        default:             out_latch_next = out_latch_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch_reg <= 1'b0;
    end else begin
      out_latch_reg <= out_latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and routing
  assign pin_owned = (action == tcm_pkg::ACT_SET) || (action == tcm_pkg::ACT_CLEAR) ||
                     (action == tcm_pkg::ACT_TOGGLE);
  assign drive_oe  = pin_owned && !pin_direction_bit;
  assign pin_main_out = out_latch_reg;
  assign pin_alt_out  = out_latch_reg;
  assign pin_main_oe  = drive_oe && !alternate_pin_select_reg[tcm_pkg::ROUTE_BIT];
  assign pin_alt_oe   = drive_oe && alternate_pin_select_reg[tcm_pkg::ROUTE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Special event trigger
  assign event_out.trigger     = (action == tcm_pkg::ACT_SEV) && match;
  // Match re-checked at the timer edge, so a moved compare value cancels it
  assign event_out.timer_reset = event_out.trigger && timer_in.tick;
  assign event_out.adc_start   = (action == tcm_pkg::ACT_SEV) && match_rise && adc_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, write one to clear, set wins
  always_comb begin
    peripheral_irq_flags_next = peripheral_irq_flags_reg;
    if (wr_en && paddr == tcm_pkg::OFF_IRQ_FLAGS) begin
      peripheral_irq_flags_next = peripheral_irq_flags_reg & ~pwdata[7:0];
    end
    if (match_rise && action != tcm_pkg::ACT_NONE) begin
      peripheral_irq_flags_next[tcm_pkg::CMP_FLAG_BIT] = 1'b1;
    end
    if (timer_in.overflow && !event_out.timer_reset) begin
      peripheral_irq_flags_next[tcm_pkg::OVF_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_flags_reg <= tcm_pkg::RST_IRQ_FLAGS;
    end else begin
      peripheral_irq_flags_reg <= peripheral_irq_flags_next;
    end
  end

  assign irq = |(peripheral_irq_flags_reg & peripheral_irq_enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cmp_flag;
    @(posedge pclk) disable iff (!presetn)
      (match && !match_prev_reg && action != tcm_pkg::ACT_NONE)
      |=> peripheral_irq_flags_reg[tcm_pkg::CMP_FLAG_BIT];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set on match");

  property p_sev_immediate;
    @(posedge pclk) disable iff (!presetn)
      (compare_mode_field == tcm_pkg::MODE_SEV && compare_value == timer_in.count) |-> event_out.trigger;
  endproperty
  a_sev_immediate: assert property (p_sev_immediate) else $error("trigger missing in match cycle");

  property p_reset_on_tick;
    @(posedge pclk) disable iff (!presetn)
      event_out.timer_reset |-> (timer_in.tick && compare_mode_field == tcm_pkg::MODE_SEV);
  endproperty
  a_reset_on_tick: assert property (p_reset_on_tick) else $error("timer reset off the timer edge");

  property p_no_reset_unmatched;
    @(posedge pclk) disable iff (!presetn)
      (compare_value != timer_in.count) |-> !event_out.timer_reset;
  endproperty
  a_no_reset_unmatched: assert property (p_no_reset_unmatched) else $error("reset without match");

  property p_ctrl_zero;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == tcm_pkg::OFF_COMPARE_CONTROL && pwdata[7:0] == 8'h00) |=> !pin_main_out;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("output latch not cleared");

  property p_swint_no_pin;
    @(posedge pclk) disable iff (!presetn)
      (compare_mode_field == tcm_pkg::MODE_SWINT) |-> (!pin_main_oe && !pin_alt_oe);
  endproperty
  a_swint_no_pin: assert property (p_swint_no_pin) else $error("pin driven in interrupt mode");

  property p_sev_no_pin;
    @(posedge pclk) disable iff (!presetn)
      (compare_mode_field == tcm_pkg::MODE_SEV) |-> (!pin_main_oe && !pin_alt_oe);
  endproperty
  a_sev_no_pin: assert property (p_sev_no_pin) else $error("pin driven in trigger mode");

  property p_toggle_once;
    @(posedge pclk) disable iff (!presetn)
      (match && match_prev_reg && !wr_en) |=> $stable(pin_main_out);
  endproperty
  a_toggle_once: assert property (p_toggle_once) else $error("output changed on held match");

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (peripheral_irq_flags_reg[tcm_pkg::CMP_FLAG_BIT] && !(wr_en && paddr == tcm_pkg::OFF_IRQ_FLAGS))
      |=> peripheral_irq_flags_reg[tcm_pkg::CMP_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("compare flag dropped");

  property p_ovf_block;
    @(posedge pclk) disable iff (!presetn)
      (!peripheral_irq_flags_reg[tcm_pkg::OVF_FLAG_BIT] && event_out.timer_reset)
      |=> !peripheral_irq_flags_reg[tcm_pkg::OVF_FLAG_BIT];
  endproperty
  a_ovf_block: assert property (p_ovf_block) else $error("trigger reset set overflow flag");

  property p_adc_start;
    @(posedge pclk) disable iff (!presetn)
      event_out.adc_start |-> (adc_enabled && event_out.trigger);
  endproperty
  a_adc_start: assert property (p_adc_start) else $error("ADC start without trigger");

  property p_toggle_acts;
    @(posedge pclk) disable iff (!presetn)
      (match_rise && action == tcm_pkg::ACT_TOGGLE && !wr_en) |=> (pin_main_out != $past(pin_main_out));
  endproperty
  a_toggle_acts: assert property (p_toggle_acts) else $error("toggle did not act");

  property p_set_acts;
    @(posedge pclk) disable iff (!presetn)
      (match_rise && action == tcm_pkg::ACT_SET && !wr_en) |=> pin_main_out;
  endproperty
  a_set_acts: assert property (p_set_acts) else $error("set did not act");

  property p_clear_acts;
    @(posedge pclk) disable iff (!presetn)
      (match_rise && action == tcm_pkg::ACT_CLEAR) |=> !pin_main_out;
  endproperty
  a_clear_acts: assert property (p_clear_acts) else $error("clear did not act");

  property p_flag_needs_match;
    @(posedge pclk) disable iff (!presetn)
      (!peripheral_irq_flags_reg[tcm_pkg::CMP_FLAG_BIT] && !(match_rise && action != tcm_pkg::ACT_NONE))
      |=> !peripheral_irq_flags_reg[tcm_pkg::CMP_FLAG_BIT];
  endproperty
  a_flag_needs_match: assert property (p_flag_needs_match) else $error("compare flag set without match");

  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
      ((action == tcm_pkg::ACT_SWINT || action == tcm_pkg::ACT_SEV) && !wr_en) |=> $stable(pin_main_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved without pin control");

  property p_sev_adc;
    @(posedge pclk) disable iff (!presetn)
      (match_rise && action == tcm_pkg::ACT_SEV && adc_enabled) |-> event_out.adc_start;
  endproperty
  a_sev_adc: assert property (p_sev_adc) else $error("ADC start missing on trigger");

  property p_adc_once;
    @(posedge pclk) disable iff (!presetn)
      event_out.adc_start |=> !event_out.adc_start;
  endproperty
  a_adc_once: assert property (p_adc_once) else $error("ADC start repeated");

  property p_route_main;
    @(posedge pclk) disable iff (!presetn)
      alternate_pin_select_reg[tcm_pkg::ROUTE_BIT] |-> !pin_main_oe;
  endproperty
  a_route_main: assert property (p_route_main) else $error("main pin driven while routed away");

  property p_route_alt;
    @(posedge pclk) disable iff (!presetn)
      !alternate_pin_select_reg[tcm_pkg::ROUTE_BIT] |-> !pin_alt_oe;
  endproperty
  a_route_alt: assert property (p_route_alt) else $error("alt pin driven while not routed");

endmodule

// *** tb/tcm_timer_model.sv ***
/*
  Model of the sixteen_bit_timer that feeds the compare unit: tick divider,
  loadable count, clear on trigger reset, raw overflow carry.
  Assumes it runs on pclk, the same clock as the unit.
*/
`timescale 1ns/10ps

module tcm_timer_model #(
  parameter int TICK_DIV = 8
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Bench control
  input  wire logic          run,
  input  wire logic          load,
  input  wire logic [15:0]   load_val,
  // Unit side
  input  wire logic          timer_reset,
  output tcm_pkg::tcm_timer_t timer_out
);
  logic [7:0]  div_reg;
  logic [15:0] count_reg;
  logic        tick;

  // Tick derived from pclk, timer synchronous
  assign tick = run && (div_reg == 8'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_reg <= 8'h00;
    else if (!run || tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // Count clears only on a tick edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_reg <= 16'h0000;
    else if (load)
      count_reg <= load_val;
    else if (tick && timer_reset)
      count_reg <= 16'h0000;
    else if (tick)
      count_reg <= count_reg + 16'h0001;
  end

  // Raw carry even on a trigger reset, unit must mask it
  assign timer_out = '{count: count_reg, tick: tick, overflow: tick && (count_reg == 16'hFFFF)};
endmodule

// *** tb/timer_compare_match_unit_bench.sv ***
/*
  Bench of the timer compare match unit: APB tasks and match scenarios.
  Assumes tcm_pkg, tcm_top and tcm_timer_model are compiled before it.
*/
`timescale 1ns/10ps

module timer_compare_match_unit_bench;
  localparam logic [7:0]  CTL = tcm_pkg::OFF_COMPARE_CONTROL;
  localparam logic [7:0]  VLO = tcm_pkg::OFF_COMPARE_VALUE_LOW;
  localparam logic [7:0]  VHI = tcm_pkg::OFF_COMPARE_VALUE_HIGH;
  localparam logic [7:0]  ALT = tcm_pkg::OFF_ALT_PIN_SELECT;
  localparam logic [7:0]  IEN = tcm_pkg::OFF_IRQ_ENABLE;
  localparam logic [7:0]  IFL = tcm_pkg::OFF_IRQ_FLAGS;
  localparam logic [7:0]  TLO = tcm_pkg::OFF_TIMER_COUNT_LOW;
  localparam logic [7:0]  THI = tcm_pkg::OFF_TIMER_COUNT_HIGH;
  localparam logic [31:0] CF  = 32'h1 << tcm_pkg::CMP_FLAG_BIT;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, r;
  tcm_pkg::tcm_timer_t timer_in;
  tcm_pkg::tcm_event_t event_out;
  logic                adc_enabled, pin_direction_bit, run, load, e;
  logic                pin_main_out, pin_main_oe, pin_alt_out, pin_alt_oe;
  logic [15:0]         load_val;
  logic [3:0]          mt [6];
  logic [5:0]          ex;
  int                  miscompares, checks_done, trig_cnt, adc_cnt, rst_cnt, a0, r0, t0;

  tcm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_in(timer_in), .adc_enabled(adc_enabled), .event_out(event_out),
    .pin_direction_bit(pin_direction_bit), .pin_main_out(pin_main_out), .pin_main_oe(pin_main_oe),
    .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe), .irq(irq));

  tcm_timer_model #(.TICK_DIV(8)) tmr_u (.pclk(pclk), .presetn(presetn), .run(run), .load(load),
    .load_val(load_val), .timer_reset(event_out.timer_reset), .timer_out(timer_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Event pulse counters
  always @(posedge pclk) begin
    trig_cnt <= trig_cnt + int'(event_out.trigger);
    adc_cnt  <= adc_cnt + int'(event_out.adc_start);
    rst_cnt  <= rst_cnt + int'(event_out.timer_reset);
  end

  task automatic complete_run();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    while (timer_in.count !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic arm(input logic [3:0] m, input logic [15:0] v, input logic [15:0] s);
    wr(CTL, {28'h0, m});
    wr(VLO, {24'h0, v[7:0]});
    wr(VHI, {24'h0, v[15:8]});
    wr(IFL, CF);
    load_val <= s;
    load     <= 1'b1;
    @(posedge pclk);
    load     <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, load, load_val, run} = '0;
    {adc_enabled, pin_direction_bit, presetn} = '0;
    mt = '{tcm_pkg::MODE_SET, tcm_pkg::MODE_TOGGLE, tcm_pkg::MODE_TOGGLE, 4'h0,
           tcm_pkg::MODE_SET, tcm_pkg::MODE_CLEAR};
    ex = 6'b010101;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    run     <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    rd(8'h20, 32'h0);
    chk(32'(e), 32'h1);
    // Set, toggle, clear and control clear sequence
    for (int i = 0; i < 6; i++) begin
      if (mt[i] == 4'h0) begin
        wr(CTL, 32'h0);
      end else begin
        arm(mt[i], 16'h0040, 16'h003E);
        wait_cnt(16'h0041);
        rd(IFL, CF);
        if (i == 0) begin
          wr(IEN, CF);
          chk(32'(irq), 32'h1);
          wr(IEN, 32'h0);
          chk(32'(irq), 32'h0);
          rd(IFL, CF);
        end
        wr(IFL, CF);
      end
      chk(32'(pin_main_out), 32'(ex[i]));
      chk(32'(pin_main_oe), 32'(mt[i] != 4'h0));
    end
    // Alternate routing and pin direction
    wr(ALT, 32'h1);
    arm(tcm_pkg::MODE_SET, 16'h0040, 16'h003E);
    wait_cnt(16'h0041);
    chk({pin_alt_out, pin_alt_oe, pin_main_oe}, 32'h6);
    pin_direction_bit <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(pin_alt_oe), 32'h0);
    pin_direction_bit <= 1'b0;
    wr(ALT, 32'h0);
    wr(IFL, CF);
    // Software interrupt mode
    arm(tcm_pkg::MODE_SWINT, 16'h0040, 16'h003E);
    wait_cnt(16'h0041);
    chk({pin_main_oe, pin_alt_oe}, 32'h0);
    rd(IFL, CF);
    chk(32'(pin_main_out), 32'h1);
    wr(IFL, CF);
    // Undecoded mode code: no action, no flag
    arm(4'h3, 16'h0040, 16'h003E);
    wait_cnt(16'h0041);
    rd(IFL, 32'h0);
    chk(32'(pin_main_out), 32'h1);
    // Special event trigger with ADC enabled
    adc_enabled <= 1'b1;
    a0 = adc_cnt;
    r0 = rst_cnt;
    arm(tcm_pkg::MODE_SEV, 16'h0040, 16'h003E);
    t0 = trig_cnt;
    wait_cnt(16'h0040);
    chk({pin_main_oe, pin_alt_oe}, 32'h0);
    wait_cnt(16'h0000);
    repeat (2) @(posedge pclk);
    chk(trig_cnt - t0, 8);
    chk(adc_cnt - a0, 1);
    chk(rst_cnt - r0, 1);
    rd(IFL, CF);
    wr(IFL, CF);
    arm(tcm_pkg::MODE_SEV, 16'hFFFF, 16'hFFFD);
    wait_cnt(16'hFFFF);
    wait_cnt(16'h0000);
    rd(IFL, CF);
    wr(IFL, CF);
    // Match removed before the reset edge, ADC off
    adc_enabled <= 1'b0;
    a0 = adc_cnt;
    r0 = rst_cnt;
    arm(tcm_pkg::MODE_SEV, 16'h0040, 16'h003E);
    wait_cnt(16'h0040);
    wr(VLO, 32'h50);
    wait_cnt(16'h0041);
    chk(rst_cnt - r0, 0);
    chk(adc_cnt - a0, 0);
    // Plain overflow sets the timer flag
    arm(tcm_pkg::MODE_SET, 16'h0040, 16'hFFFE);
    wait_cnt(16'h0001);
    rd(IFL, 32'h1);
    // Timer count mirror is read-only
    run      <= 1'b0;
    load_val <= 16'h1234;
    load     <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wr(TLO, 32'hFF);
    rd(TLO, 32'h34);
    rd(THI, 32'h12);
    complete_run();
  end
endmodule
